// ### design/misa_top.sv
// Purpose: Interrupt source aggregator between peripherals and CPU core.
// Assumes: Peripheral events are one-cycle pulses on the bus clock.
// Notes: Flags clear through flag_clr, the tick flag through tick_ack_bit; requests refresh every cycle.
`timescale 1ns/1ps
module misa_top #(
  parameter int TW = misa_pkg::TICK_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // CPU core side
  input wire logic global_mask,
  input wire logic soft_trap_instr,
  input wire logic cpu_ack,
  input wire logic [15:0] cpu_pc,
  output logic irq_req_r,
  output logic [4:0] irq_prio_r,
  output logic [15:0] stack_pc_r,
  output logic trap_insert_r,
  // Break unit
  input wire logic break_hit,
  // Flag clears and interrupt enables, indexed by flag
  input wire logic [misa_pkg::NFLAG-1:0] flag_clr,
  input wire logic [misa_pkg::NFLAG-1:0] irq_en,
  // External pins
  input wire logic ext_request_pin_n,
  input wire logic [4:0] keypad_pins_n,
  // Clock generator
  input wire logic pll_lock,
  // Timers
  input wire logic [1:0][15:0] tmr_count,
  input wire logic [1:0][15:0] tmr_modulo,
  input wire logic [2:0] tmr_chan_evt,
  // SPI
  input wire logic spi_byte_done,
  input wire logic spi_tx_load,
  input wire logic spi_master,
  input wire logic spi_busy,
  input wire logic spi_ss_n,
  input wire logic spi_select_fault_detect_en,
  // UART
  input wire logic uart_tx_load,
  input wire logic uart_tx_shift_empty,
  input wire logic uart_tx_data_empty,
  input wire logic uart_break_idle_busy,
  input wire logic uart_char_done,
  input wire logic uart_bit_tick,
  input wire logic uart_rxd,
  input wire logic uart_nine_bit,
  input wire logic uart_stop_tick,
  input wire logic uart_noise_evt,
  input wire logic uart_parity_evt,
  // ADC
  input wire logic adc_conv_done,
  input wire logic adc_data_read,
  // Periodic tick unit
  input wire logic tick_run,
  input wire logic [2:0] tick_rate_select,
  input wire logic tick_ack_bit,
  // Status outputs
  output logic [misa_pkg::NFLAG-1:0] periph_flags,
  output logic conv_done_flag,
  output logic [misa_pkg::IF_LAST:misa_pkg::IF_FIRST] source_pending_flags,
  output logic [7:0] int_status_1,
  output logic [7:0] int_status_2,
  output logic [7:0] int_status_3
);
  ////////////////////////////////////////////////////////////////////////////
  // Flag bank
  misa_flag_if #(.N(misa_pkg::NFLAG)) fl ();
  logic [misa_pkg::NFLAG-1:0] set_v;
  logic [misa_pkg::NFLAG-1:0] clr_v;

  misa_flag_bank #(.N(misa_pkg::NFLAG)) u_flags (
    .clock(clock),
    .rst_n(rst_n),
    .fl(fl.bank)
  );

  // Drive the carrier
  assign fl.set = set_v;
  assign fl.clr = clr_v;
  assign periph_flags = fl.flag;

  ////////////////////////////////////////////////////////////////////////////
  // Edge and history registers
  logic pll_q_r;
  logic ss_q_r;
  logic [1:0] tmr_match_r;
  logic [1:0] tmr_wrap;

  // Previous PLL lock and select levels
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pll_q_r <= 1'b0;
      ss_q_r <= 1'b1;
    end else begin
      pll_q_r <= pll_lock;
      ss_q_r <= spi_ss_n;
    end
  end

  // Timer wrap: counter reads zero right after matching modulo
  genvar t;
  generate
    for (t = 0; t < 2; t++) begin : g_tmr
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          tmr_match_r[t] <= 1'b0;
        end else begin
          tmr_match_r[t] <= (tmr_count[t] == tmr_modulo[t]);
        end
      end
      assign tmr_wrap[t] = tmr_match_r[t] &&
                           (tmr_count[t] == misa_pkg::TMR_WRAP);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // UART idle line counter
  logic [3:0] idle_cnt_r;
  logic [3:0] idle_target;
  logic idle_evt;

  assign idle_target = uart_nine_bit ? misa_pkg::IDLE_BITS_LONG
                                     : misa_pkg::IDLE_BITS_SHORT;
  assign idle_evt = uart_bit_tick && uart_rxd &&
                    (idle_cnt_r == idle_target - 4'h1);

  // Count consecutive high bits, saturate at the target
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt_r <= 4'h0;
    end else if (uart_bit_tick) begin
      if (!uart_rxd) begin
        idle_cnt_r <= 4'h0;
      end else if (idle_cnt_r != idle_target) begin
        idle_cnt_r <= idle_cnt_r + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Periodic tick counter chain
  logic [TW-1:0] tick_cnt_r;
  logic [TW-1:0] tick_mask;
  logic [4:0] tick_tap;
  logic tick_evt;

  assign tick_tap = misa_pkg::TICK_TAP0 + 5'({tick_rate_select, 1'b0});
  assign tick_mask = ~({TW{1'b1}} << tick_tap);
  assign tick_evt = tick_run && ((tick_cnt_r & tick_mask) == tick_mask);

  // Free counter while the tick unit runs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= '0;
    end else if (tick_run) begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end else begin
      tick_cnt_r <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ADC completion status when interrupts are off
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      conv_done_flag <= 1'b0;
    end else if (adc_conv_done && !irq_en[misa_pkg::F_ADC]) begin
      conv_done_flag <= 1'b1;
    end else if (adc_data_read || irq_en[misa_pkg::F_ADC]) begin
      conv_done_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag set terms
  always_comb begin
    set_v = '0;
    set_v[misa_pkg::F_EXT] = !ext_request_pin_n;
    set_v[misa_pkg::F_PLL] = (pll_lock != pll_q_r);
    set_v[misa_pkg::F_T1C0] = tmr_chan_evt[0];
    set_v[misa_pkg::F_T1C1] = tmr_chan_evt[1];
    set_v[misa_pkg::F_T1OV] = tmr_wrap[0];
    set_v[misa_pkg::F_T2C0] = tmr_chan_evt[2];
    set_v[misa_pkg::F_T2OV] = tmr_wrap[1];
    // Byte lands in receive register unless the last one is unread
    set_v[misa_pkg::F_SRX] = spi_byte_done &&
                             !fl.flag[misa_pkg::F_SRX];
    set_v[misa_pkg::F_SOVR] = spi_byte_done &&
                              fl.flag[misa_pkg::F_SRX];
    set_v[misa_pkg::F_SMOD] = spi_select_fault_detect_en &&
      (spi_master ? !spi_ss_n
                  : (spi_busy && spi_ss_n && !ss_q_r));
    set_v[misa_pkg::F_STX] = spi_tx_load;
    set_v[misa_pkg::F_UOR] = uart_char_done &&
                             fl.flag[misa_pkg::F_URX];
    set_v[misa_pkg::F_UNF] = uart_noise_evt;
    set_v[misa_pkg::F_UFE] = uart_stop_tick && !uart_rxd;
    set_v[misa_pkg::F_UPE] = uart_parity_evt;
    set_v[misa_pkg::F_URX] = uart_char_done &&
                             !fl.flag[misa_pkg::F_URX];
    set_v[misa_pkg::F_UIDL] = idle_evt;
    set_v[misa_pkg::F_UTXE] = uart_tx_load;
    set_v[misa_pkg::F_UTC] = uart_tx_shift_empty && uart_tx_data_empty &&
                             !uart_break_idle_busy;
    set_v[misa_pkg::F_KBD] = |(~keypad_pins_n);
    set_v[misa_pkg::F_ADC] = adc_conv_done &&
                             irq_en[misa_pkg::F_ADC];
    set_v[misa_pkg::F_TICK] = tick_evt;
  end

  // Flag clear terms; the tick flag clears by a one on its ack bit
  always_comb begin
    clr_v = flag_clr;
    clr_v[misa_pkg::F_TICK] = tick_ack_bit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gated requests folded onto pending flag numbers
  logic [misa_pkg::NFLAG-1:0] req;
  logic [misa_pkg::IF_LAST:misa_pkg::IF_FIRST] pend;

  assign req = fl.flag & irq_en;

  always_comb begin
    pend = '0;
    pend[1] = req[misa_pkg::F_EXT];
    pend[2] = req[misa_pkg::F_PLL];
    pend[3] = req[misa_pkg::F_T1C0];
    pend[4] = req[misa_pkg::F_T1C1];
    pend[5] = req[misa_pkg::F_T1OV];
    pend[6] = req[misa_pkg::F_T2C0];
    pend[misa_pkg::IF_RSVD] = 1'b0;
    pend[8] = req[misa_pkg::F_T2OV];
    pend[9] = req[misa_pkg::F_SRX] | req[misa_pkg::F_SOVR] |
              req[misa_pkg::F_SMOD];
    pend[10] = req[misa_pkg::F_STX];
    pend[11] = req[misa_pkg::F_UOR] | req[misa_pkg::F_UNF] |
               req[misa_pkg::F_UFE] | req[misa_pkg::F_UPE];
    pend[12] = req[misa_pkg::F_URX] | req[misa_pkg::F_UIDL];
    pend[13] = req[misa_pkg::F_UTXE] | req[misa_pkg::F_UTC];
    pend[14] = req[misa_pkg::F_KBD];
    pend[15] = req[misa_pkg::F_ADC];
    pend[16] = req[misa_pkg::F_TICK];
  end

  // Most urgent pending number: smallest index wins
  logic [4:0] first_if;
  always_comb begin
    first_if = 5'h00;
    for (int i = misa_pkg::IF_LAST; i >= misa_pkg::IF_FIRST; i--) begin
      if (pend[i]) begin
        first_if = 5'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software trap latch, also raised by the break unit
  logic trap_r;
  logic trap_nxt;

  assign trap_nxt = soft_trap_instr || break_hit || (trap_r &&
                    !(cpu_ack && irq_prio_r == misa_pkg::PRIO_TRAP));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      trap_r <= 1'b0;
    end else begin
      trap_r <= trap_nxt;
    end
  end

  // Break hit tells the CPU to run the trap instruction
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      trap_insert_r <= 1'b0;
    end else begin
      trap_insert_r <= break_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CPU request, priority and stacked PC
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_req_r <= 1'b0;
      irq_prio_r <= misa_pkg::PRIO_TRAP;
      stack_pc_r <= 16'h0000;
    end else if (trap_nxt) begin
      irq_req_r <= 1'b1;
      irq_prio_r <= misa_pkg::PRIO_TRAP;
      stack_pc_r <= cpu_pc;
    end else begin
      irq_req_r <= !global_mask && (|pend);
      irq_prio_r <= first_if;
      stack_pc_r <= cpu_pc - misa_pkg::PC_STEP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-only status bytes, unused bits zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      source_pending_flags <= '0;
      int_status_1 <= misa_pkg::STAT_RESET;
      int_status_2 <= misa_pkg::STAT_RESET;
      int_status_3 <= misa_pkg::STAT_RESET;
    end else begin
      source_pending_flags <= pend;
      int_status_1 <= {pend[6:1], 2'b00};
      int_status_2 <= pend[14:7];
      int_status_3 <= {6'h00, pend[16:15]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_mask_blocks: assert property (
    global_mask && !trap_nxt |=> !irq_req_r)
    else $error("masked request reached the CPU");
  a_prio_lowest: assert property (
    !trap_nxt && !global_mask && pend[1] |=> irq_prio_r == 5'h01)
    else $error("highest priority not chosen");
  a_trap_unmasked: assert property (
    soft_trap_instr |=> irq_req_r && irq_prio_r == misa_pkg::PRIO_TRAP)
    else $error("trap did not request");
  a_trap_pc: assert property (
    trap_nxt |=> stack_pc_r == $past(cpu_pc))
    else $error("trap stacked wrong PC");
  a_hw_pc: assert property (
    !trap_nxt |=> stack_pc_r == $past(cpu_pc) - misa_pkg::PC_STEP)
    else $error("hardware stacked wrong PC");
  a_break_trap: assert property (
    break_hit |=> trap_insert_r && irq_req_r)
    else $error("break did not force trap");
  a_ext_latch: assert property (
    !ext_request_pin_n |=> periph_flags[misa_pkg::F_EXT])
    else $error("external pin not latched");
  a_pll_edge: assert property (
    pll_lock != pll_q_r |=> periph_flags[misa_pkg::F_PLL])
    else $error("lock change missed");
  a_idle_len: assert property (
    idle_evt |=> periph_flags[misa_pkg::F_UIDL])
    else $error("idle set at wrong count");
  a_tick_ack: assert property (
    tick_ack_bit && !tick_evt |=> !periph_flags[misa_pkg::F_TICK])
    else $error("tick ack failed");
  a_status_zero: assert property (
    int_status_1[1:0] == 2'b00 && int_status_2[0] == 1'b0 &&
    int_status_3[7:2] == 6'h00)
    else $error("unused status bit set");
  a_status_lag: assert property (
    ##1 int_status_3[1] == $past(pend[16]))
    else $error("status lags pending");

  c_trap: cover property (soft_trap_instr ##1 irq_req_r);
  c_masked: cover property (global_mask && (|pend) ##1 !irq_req_r);
  c_spi_ovr: cover property (set_v[misa_pkg::F_SOVR]);
  c_tick: cover property (tick_evt ##[1:8] tick_ack_bit);
endmodule : misa_top

// ### design/misa_pkg.sv
// Purpose: Shared constants for the interrupt source aggregator.
// Assumes: One bus clock; peripheral events arrive as one-cycle pulses.
// Notes: Flag indices name the internal sticky flags of the flag bank.
// Behaviour
// - Global mask blocks all maskable requests.
// - Fixed priority, zero most urgent.
// - Software trap always raises unmaskable interrupt.
// - Trap stacks PC; hardware stacks PC-1.
// - Breakpoint makes CPU execute software trap.
// - Low external pin latches pending request.
// - PLL lock change sets flag; enable gates.
// - Timer one wrap and channel 0/1 flags.
// - Timer two wrap and channel 0 flags.
// - SPI receive transfer sets receive-full flag.
// - SPI transmit transfer sets transmit-empty flag.
// - SPI select fault per master/slave mode.
// - SPI overflow when unread byte overwritten.
// - UART hand-off sets transmit-empty flag.
// - UART idle shifter and data set done unless break/idle busy.
// - UART received character sets receive-full flag.
// - Ten or eleven high bits set idle.
// - Four UART errors share one request.
// - Low keypad pin latches pending request.
// - ADC requests per conversion when enabled.
// - Tick flag on rollover, acknowledged by one.
// - Pending flags 1..16 in priority order.
// - Three read-only status bytes, reset zero.
package misa_pkg;
  // Sticky flag indices
  localparam int F_EXT = 0;
  localparam int F_PLL = 1;
  localparam int F_T1C0 = 2;
  localparam int F_T1C1 = 3;
  localparam int F_T1OV = 4;
  localparam int F_T2C0 = 5;
  localparam int F_T2OV = 6;
  localparam int F_SRX = 7;
  localparam int F_SOVR = 8;
  localparam int F_SMOD = 9;
  localparam int F_STX = 10;
  localparam int F_UOR = 11;
  localparam int F_UNF = 12;
  localparam int F_UFE = 13;
  localparam int F_UPE = 14;
  localparam int F_URX = 15;
  localparam int F_UIDL = 16;
  localparam int F_UTXE = 17;
  localparam int F_UTC = 18;
  localparam int F_KBD = 19;
  localparam int F_ADC = 20;
  localparam int F_TICK = 21;
  localparam int NFLAG = 22;
  // Pending flag numbering and priority
  localparam int IF_FIRST = 1;
  localparam int IF_LAST = 16;
  localparam int IF_RSVD = 7;
  localparam logic [4:0] PRIO_TRAP = 5'h00;
  // Status byte offsets
  localparam logic [15:0] STAT1_ADDR = 16'hFE04;
  localparam logic [15:0] STAT2_ADDR = 16'hFE05;
  localparam logic [15:0] STAT3_ADDR = 16'hFE06;
  localparam logic [7:0] STAT_RESET = 8'h00;
  // Idle line length in bit times
  localparam logic [3:0] IDLE_BITS_SHORT = 4'hA;
  localparam logic [3:0] IDLE_BITS_LONG = 4'hB;
  // Tick chain: width and first tap; stacked PC step; timer wrap count
  localparam int TICK_W = 18;
  localparam logic [4:0] TICK_TAP0 = 5'h03;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [15:0] TMR_WRAP = 16'h0000;
endpackage : misa_pkg

// ### design/misa_flag_if.sv
// Purpose: Carrier between the aggregator and its flag bank.
// Assumes: Set and clear are one-cycle pulses per flag.
// Notes: Flag outputs come straight from flip-flops.
`timescale 1ns/1ps
interface misa_flag_if #(parameter int N = 22);
  logic [N-1:0] set;
  logic [N-1:0] clr;
  logic [N-1:0] flag;
  modport bank (input set, input clr, output flag);
  modport user (output set, output clr, input flag);
endinterface : misa_flag_if

// ### design/misa_flag_bank.sv
// Purpose: Bank of sticky event flags.
// Assumes: Set and clear sampled on the bus clock.
// Notes: A set in the clearing cycle keeps the flag.
`timescale 1ns/1ps
module misa_flag_bank #(
  parameter int N = 22
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Flag carrier
  misa_flag_if.bank fl
);
  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_flag
      // Per-flag sticky store, set beats clear
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          fl.flag[g] <= 1'b0;
        end else if (fl.set[g]) begin
          fl.flag[g] <= 1'b1;
        end else if (fl.clr[g]) begin
          fl.flag[g] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_set_wins: assert property (fl.set[0] |=> fl.flag[0])
    else $error("flag 0 lost its set");
  a_clr_only: assert property (fl.clr[N-1] && !fl.set[N-1] |=> !fl.flag[N-1])
    else $error("flag did not clear");
endmodule : misa_flag_bank

// ### bench/misa_cpu_model.sv
// Purpose: Behavioural CPU core facing the interrupt aggregator.
// Assumes: The core acknowledges a standing request after a set latency.
// Notes: Taking the tick source also pulses the tick acknowledge bit.
`timescale 1ns/1ps
module misa_cpu_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Bench control
  input wire logic ack_en,
  input wire logic [3:0] ack_lat,
  // Aggregator side
  input wire logic irq_req_r,
  input wire logic [4:0] irq_prio_r,
  output logic cpu_ack,
  output logic tick_ack_bit
);
  logic [3:0] wait_r;
  //////////////////////////////////////////////////////////////////////////
  // Count request cycles and acknowledge once the latency has passed
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 4'h0;
      cpu_ack <= 1'b0;
      tick_ack_bit <= 1'b0;
    end else begin
      cpu_ack <= 1'b0;
      tick_ack_bit <= 1'b0;
      wait_r <= 4'h0;
      if (ack_en && irq_req_r && !cpu_ack) begin
        wait_r <= wait_r + 4'h1;
        if (wait_r >= ack_lat) begin
          wait_r <= 4'h0;
          cpu_ack <= 1'b1;
          tick_ack_bit <= (irq_prio_r == 5'h10);
        end
      end
    end
  end
endmodule : misa_cpu_model

// ### bench/misa_top_tb.sv
// Purpose: Self-checking bench for the interrupt source aggregator.
// Assumes: Event inputs are one-cycle pulses driven at the rising edge.
// Notes: Most scenarios clear all flags first; the priority and trap checks run on from the flags left before them.
`timescale 1ns/1ps
module misa_top_tb;
  logic clock, rst_n, global_mask, pll_lock, spi_master, spi_busy, spi_ss_n;
  logic spi_select_fault_detect_en, uart_tx_shift_empty, uart_tx_data_empty;
  logic uart_break_idle_busy, uart_rxd, uart_nine_bit, tick_run, ack_en;
  logic ext_request_pin_n, cpu_ack, tick_ack_bit, irq_req_r, trap_insert_r;
  logic conv_done_flag;
  logic [14:0] pz;
  logic [4:0] keypad_pins_n, irq_prio_r;
  logic [2:0] tick_rate_select;
  logic [3:0] ack_lat;
  logic [15:0] cpu_pc, stack_pc_r;
  logic [1:0][15:0] tmr_count, tmr_modulo;
  logic [misa_pkg::NFLAG-1:0] flag_clr, irq_en, periph_flags;
  logic [16:1] source_pending_flags;
  logic [7:0] int_status_1, int_status_2, int_status_3;
  int fails, cmp_count, k;
  int fl[10] = '{misa_pkg::F_T1C0, misa_pkg::F_T1C1, misa_pkg::F_T2C0,
    misa_pkg::F_SRX, misa_pkg::F_STX, misa_pkg::F_UTXE, misa_pkg::F_URX,
    misa_pkg::F_UNF, misa_pkg::F_UPE, misa_pkg::F_ADC};
  int pn[10] = '{3, 4, 6, 9, 10, 13, 12, 11, 11, 15};
  // Event pulses share one vector, indexed by scenario tables
  wire [2:0] tmr_chan_evt = pz[2:0];
  wire spi_byte_done = pz[3];
  wire spi_tx_load = pz[4];
  wire uart_tx_load = pz[5];
  wire uart_char_done = pz[6];
  wire uart_noise_evt = pz[7];
  wire uart_parity_evt = pz[8];
  wire adc_conv_done = pz[9];
  wire uart_bit_tick = pz[10];
  wire uart_stop_tick = pz[11];
  wire soft_trap_instr = pz[12];
  wire break_hit = pz[13];
  wire adc_data_read = pz[14];
  //////////////////////////////////////////////////////////////////////////
  // Design and core model
  misa_top dut_u (.clock, .rst_n, .global_mask, .soft_trap_instr, .cpu_ack,
    .cpu_pc, .irq_req_r, .irq_prio_r, .stack_pc_r, .trap_insert_r,
    .break_hit, .flag_clr, .irq_en, .ext_request_pin_n, .keypad_pins_n,
    .pll_lock, .tmr_count, .tmr_modulo, .tmr_chan_evt, .spi_byte_done,
    .spi_tx_load, .spi_master, .spi_busy, .spi_ss_n,
    .spi_select_fault_detect_en, .uart_tx_load, .uart_tx_shift_empty,
    .uart_tx_data_empty, .uart_break_idle_busy, .uart_char_done,
    .uart_bit_tick, .uart_rxd, .uart_nine_bit, .uart_stop_tick,
    .uart_noise_evt, .uart_parity_evt, .adc_conv_done, .adc_data_read,
    .tick_run, .tick_rate_select, .tick_ack_bit, .periph_flags,
    .conv_done_flag, .source_pending_flags, .int_status_1, .int_status_2,
    .int_status_3);
  misa_cpu_model core_u (.clock, .rst_n, .ack_en, .ack_lat, .irq_req_r,
    .irq_prio_r, .cpu_ack, .tick_ack_bit);
  //////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic fire(input int b);
    @(posedge clock);
    pz[b] <= 1'b1;
    @(posedge clock);
    pz <= '0;
    tick(3);
    #1;
  endtask : fire
  task automatic clear_all();
    @(posedge clock);
    flag_clr <= '1;
    @(posedge clock);
    flag_clr <= '0;
    tick(3);
    #1;
  endtask : clear_all
  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  //////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    tick(20000);
    fails++;
    close_out();
  end
  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0; global_mask = 1'b0; pll_lock = 1'b0; spi_master = 1'b0;
    spi_busy = 1'b0; spi_ss_n = 1'b1; spi_select_fault_detect_en = 1'b0;
    uart_tx_shift_empty = 1'b0; uart_tx_data_empty = 1'b0; uart_rxd = 1'b1;
    uart_break_idle_busy = 1'b0; uart_nine_bit = 1'b0; tick_run = 1'b0;
    ack_en = 1'b0; ack_lat = 4'h2; ext_request_pin_n = 1'b1; pz = '0;
    keypad_pins_n = 5'h1F; tick_rate_select = 3'h0; cpu_pc = 16'h1234;
    tmr_count = '0; tmr_modulo = {16'h0005, 16'h0005}; flag_clr = '0;
    irq_en = '1; fails = 0; cmp_count = 0;
    tick(3);
    rst_n <= 1'b1;
    tick(1);
    #1;
    chk({int_status_3, int_status_2, int_status_1, irq_req_r}, 0, "rst");
    // Ten pulsed event sources alone: flag, pending bit, status byte, request
    for (int i = 0; i < 10; i++) begin
      clear_all();
      fire(i);
      chk(periph_flags[fl[i]], 1, "flag");
      chk(source_pending_flags, 16'h1 << (pn[i] - 1), "pend");
      chk({int_status_3, int_status_2, int_status_1},
          24'h1 << (pn[i] + 1), "stat");
      chk({irq_req_r, irq_prio_r, stack_pc_r},
          {1'b1, 5'(pn[i]), 16'h1233}, "req");
      chk(conv_done_flag, 0, "conv");
    end
    // Enable gating, then the global mask
    clear_all();
    irq_en[misa_pkg::F_T1C0] <= 1'b0;
    fire(0);
    chk({source_pending_flags[3], irq_req_r}, 0, "gate");
    irq_en[misa_pkg::F_T1C0] <= 1'b1;
    global_mask <= 1'b1;
    tick(3);
    #1;
    chk({source_pending_flags[3], irq_req_r}, 2'b10, "mask");
    global_mask <= 1'b0;
    // Priority among ADC, timer channel and external pin
    fire(9);
    chk(irq_prio_r, 3, "prio");
    @(posedge clock);
    ext_request_pin_n <= 1'b0;
    @(posedge clock);
    ext_request_pin_n <= 1'b1;
    tick(3);
    #1;
    chk({irq_prio_r, source_pending_flags[1]}, {5'h01, 1'b1}, "ext");
    @(posedge clock);
    keypad_pins_n <= 5'h1B;
    tick(3);
    #1;
    chk(source_pending_flags[14], 1, "kbd");
    keypad_pins_n <= 5'h1F;
    // ADC status only when its interrupt is off; data read clears it
    clear_all();
    irq_en[misa_pkg::F_ADC] <= 1'b0;
    fire(9);
    chk(conv_done_flag, 1, "coco");
    fire(14);
    chk(conv_done_flag, 0, "coco rd");
    irq_en[misa_pkg::F_ADC] <= 1'b1;
    // Software trap under mask, then break insertion
    global_mask <= 1'b1;
    cpu_pc <= 16'h2000;
    fire(12);
    chk({irq_req_r, irq_prio_r, stack_pc_r}, {6'h20, 16'h2000}, "trap");
    ack_en <= 1'b1;
    tick(6);
    ack_en <= 1'b0;
    #1;
    chk(irq_req_r, 0, "ack");
    @(posedge clock);
    pz[13] <= 1'b1;
    @(posedge clock);
    pz <= '0;
    #1;
    chk({trap_insert_r, irq_req_r, irq_prio_r}, 7'h60, "brk");
    tick(1);
    #1;
    chk(trap_insert_r, 0, "brk end");
    ack_en <= 1'b1;
    tick(6);
    ack_en <= 1'b0;
    global_mask <= 1'b0;
    // Counter wrap after modulo match, both timers
    for (int j = 0; j < 2; j++) begin
      clear_all();
      tmr_count[j] <= 16'h0005;
      @(posedge clock);
      tmr_count[j] <= 16'h0000;
      tick(4);
      #1;
      chk(periph_flags[misa_pkg::F_T1OV + 2 * j], 1, "wrap");
    end
    // Lock change in both directions
    for (int j = 0; j < 2; j++) begin
      clear_all();
      pll_lock <= ~pll_lock;
      tick(3);
      #1;
      chk(source_pending_flags[2], 1, "pll");
    end
    // SPI overflow and master select fault
    clear_all();
    fire(3);
    fire(3);
    chk(periph_flags[misa_pkg::F_SOVR], 1, "ovr");
    {spi_master, spi_select_fault_detect_en, spi_ss_n} <= 3'b110;
    tick(3);
    #1;
    chk(periph_flags[misa_pkg::F_SMOD], 1, "spi_select_fault_flag");
    {spi_master, spi_select_fault_detect_en, spi_ss_n} <= 3'b001;
    // Slave: select rising while busy is a fault, a low level is not
    clear_all();
    {spi_busy, spi_select_fault_detect_en, spi_ss_n} <= 3'b110;
    tick(3);
    #1;
    chk(periph_flags[misa_pkg::F_SMOD], 0, "spi_select_fault_flag low");
    spi_ss_n <= 1'b1;
    tick(3);
    #1;
    chk(periph_flags[misa_pkg::F_SMOD], 1, "spi_select_fault_flag slave");
    {spi_busy, spi_select_fault_detect_en} <= 2'b00;
    // Idle line needs ten high bit times, eleven with nine-bit data
    for (int m = 0; m < 2; m++) begin
      clear_all();
      for (int j = 0; j < 9 + m; j++) fire(10);
      chk(periph_flags[misa_pkg::F_UIDL], 0, "idle short");
      fire(10);
      chk(periph_flags[misa_pkg::F_UIDL], 1, "idle");
      // Low bit restarts the idle count, low stop bit is a framing error
      uart_rxd <= 1'b0;
      fire(10);
      fire(11);
      chk(periph_flags[misa_pkg::F_UFE], 1, "frame");
      uart_rxd <= 1'b1;
      uart_nine_bit <= (m == 0);
    end
    // Transmission complete only with break or idle generation off
    clear_all();
    {uart_tx_shift_empty, uart_tx_data_empty, uart_break_idle_busy} <= '1;
    tick(3);
    #1;
    chk(periph_flags[misa_pkg::F_UTC], 0, "tc busy");
    uart_break_idle_busy <= 1'b0;
    tick(3);
    #1;
    chk(periph_flags[misa_pkg::F_UTC], 1, "tc");
    {uart_tx_shift_empty, uart_tx_data_empty} <= '0;
    // Tick flag rises, core acknowledges it, flag drops
    clear_all();
    ack_en <= 1'b1;
    tick_run <= 1'b1;
    tick_rate_select <= 3'h1;
    k = 0;
    // Rate code 1 taps bit 5: first rollover after 32 cycles
    while (periph_flags[misa_pkg::F_TICK] !== 1'b1 && k < 40) begin
      tick(1);
      #1;
      k++;
    end
    chk(k, 32, "tick set");
    while (periph_flags[misa_pkg::F_TICK] !== 1'b0 && k < 80) begin
      tick(1);
      #1;
      k++;
    end
    chk(k < 80, 1, "tick ack");
    close_out();
  end
endmodule : misa_top_tb
